// ==== inc/pbmux_consts.svh ====
`ifndef PBMUX_CONSTS_SVH
`define PBMUX_CONSTS_SVH

// Port geometry
`define PBMUX_PORT_W 8
`define PBMUX_ANA_W 5
`define PBMUX_KEY_W 4
`define PBMUX_IRQ_W 3

// Pin positions on port B
`define PBMUX_BIT_FAULT 0
`define PBMUX_BIT_EPWM_C 1
`define PBMUX_BIT_EPWM_B 2
`define PBMUX_BIT_CAPTURE_COMPARE_CH2 3
`define PBMUX_BIT_EPWM_D 4
`define PBMUX_BIT_PROG_ENTRY 5
`define PBMUX_BIT_PROG_CLK 6
`define PBMUX_BIT_PROG_DATA 7
`define PBMUX_KEY_BASE 4

// Analog converter channel numbers and the lowest one on this port
`define PBMUX_ANA_CH_BASE 8
`define PBMUX_CH_OF_BIT0 12
`define PBMUX_CH_OF_BIT1 10
`define PBMUX_CH_OF_BIT2 8
`define PBMUX_CH_OF_BIT3 9
`define PBMUX_CH_OF_BIT4 11

// Enhanced PWM enable positions
`define PBMUX_EPWM_B 0
`define PBMUX_EPWM_C 1
`define PBMUX_EPWM_D 2

// Reset values
`define PBMUX_ANSEL_RST 5'h00
`define PBMUX_ANSEL_ALL 5'h1F
`define PBMUX_PORT_RST 8'h00
`define PBMUX_FUSE_ALT_RST 1'b1
`define PBMUX_FUSE_ANA_RST 1'b0
`define PBMUX_FUSE_LVP_RST 1'b0

`endif

// ==== inc/pbmux_pkg.sv ====
package pbmux_pkg;

    // Configuration fuses as caught after power-on reset
    typedef struct packed {
        logic alt_capture_pin_fuse;
        logic analog_default_fuse;
        logic low_voltage_prog_fuse;
    } pbmux_fuse_t;

    // Fuse capture sequence
    typedef enum logic [1:0] {
        PBMUX_FUSE_WAIT = 2'b00,
        PBMUX_FUSE_LOAD = 2'b01,
        PBMUX_FUSE_RUN = 2'b10
    } pbmux_fuse_state_t;

    // Drive of one port pin
    typedef struct packed {
        logic level;
        logic enable;
    } pbmux_drive_t;

endpackage : pbmux_pkg

// ==== logic/pbmux_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbmux_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else if (clk_en_i) begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : pbmux_sync
`default_nettype wire

// ==== logic/pbmux_fuse_latch.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pbmux_consts.svh"
module pbmux_fuse_latch
    import pbmux_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire pbmux_fuse_t fuse_pins_i,
    output pbmux_fuse_t fuse_o,
    output logic load_o
);
    pbmux_fuse_state_t state;
    pbmux_fuse_state_t next_state;

    // Fuses are levels caught after release, never by the reset itself
    always_comb begin
        case (state)
            PBMUX_FUSE_WAIT: next_state = PBMUX_FUSE_LOAD;
            PBMUX_FUSE_LOAD: next_state = PBMUX_FUSE_RUN;
            PBMUX_FUSE_RUN: next_state = PBMUX_FUSE_RUN;
            default: next_state = PBMUX_FUSE_WAIT;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= PBMUX_FUSE_WAIT;
            fuse_o <= {`PBMUX_FUSE_ALT_RST, `PBMUX_FUSE_ANA_RST, `PBMUX_FUSE_LVP_RST};
            load_o <= 1'b0;
        end else if (clk_en_i) begin
            state <= next_state;
            load_o <= (state == PBMUX_FUSE_WAIT);
            if (state == PBMUX_FUSE_WAIT) begin
                fuse_o <= fuse_pins_i;
            end
        end
    end
endmodule : pbmux_fuse_latch
`default_nettype wire

// ==== logic/pbmux_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pbmux_consts.svh"
// Notes on behaviour
// - Fuse cleared: channel 2 on bit 3
// - Fuse default one: channel 2 on port C1
// - Direction zero drives latch; analog irrelevant
// - Direction one: data input, analog kills pull-up
// - Reset: bits 0-4 analog per analog fuse
// - Low-voltage fuse: bit 5 entry input only
// - Programming/debug disables other bit 6/7 functions
// - Programmer clock taken on bit 6
// - Bit 7 bidirectional programming data
// - Bits 4-7 inputs feed key change lines
// - Bits 0-2 inputs feed external interrupts
// - Bit 0 feeds PWM fault when enabled
// - 28-pin: bits 2,1,4 output PWM B,C,D
// - Channel 2 on bit 3: compare out, capture in
// - Bits 0-4 map converter channels 12,10,8,9,11
// - Bits 1,3 comparator inverting inputs 3,2
// - Pull-up needs enable bit, global disable clear
// - Pull-up off on outputs and at reset
module pbmux_top
    import pbmux_pkg::*;
#(
    parameter bit PIN28 = 1'b1,
    parameter int PORT_W = `PBMUX_PORT_W,
    parameter int ANA_W = `PBMUX_ANA_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire pbmux_fuse_t fuse_pins_i,
    input wire logic [PORT_W-1:0] direction_bit_i,
    input wire logic [PORT_W-1:0] portb_output_latch_i,
    input wire logic [PORT_W-1:0] pullup_enable_bits_i,
    input wire logic pullup_global_dis_i,
    input wire logic analog_sel_wr_i,
    input wire logic [ANA_W-1:0] analog_sel_wdata_i,
    input wire logic [2:0] epwm_en_i,
    input wire logic epwm_out_b_i,
    input wire logic epwm_out_c_i,
    input wire logic epwm_out_d_i,
    input wire logic capture_compare_ch2_en_i,
    input wire logic capture_compare_ch2_i,
    input wire logic pwm_fault_en_i,
    input wire logic prog_debug_active_i,
    input wire logic prog_data_oe_i,
    input wire logic prog_data_out_i,
    input wire logic portc_bit1_dir_i,
    input wire logic portc_bit1_latch_i,
    input wire logic [PORT_W-1:0] portb_pin_i,
    input wire logic portc_bit1_pin_i,
    output logic [PORT_W-1:0] portb_pin_o,
    output logic [PORT_W-1:0] portb_pin_oe_o,
    output logic [PORT_W-1:0] portb_pullup_o,
    output logic portc_bit1_pin_o,
    output logic portc_bit1_pin_oe_o,
    output logic [PORT_W-1:0] portb_data_o,
    output logic [ANA_W-1:0] analog_sel_o,
    output logic [ANA_W-1:0] analog_ch_en_o,
    output logic comparator_neg_in2_en_o,
    output logic comparator_neg_in3_en_o,
    output logic [2:0] ext_irq_in_o,
    output logic [3:0] key_change_in_o,
    output logic pwm_fault_in_o,
    output logic capture_compare_ch2_capture_o,
    output logic capture_compare_ch2_on_portb_o,
    output logic prog_entry_input_o,
    output logic prog_serial_clock_o,
    output logic prog_serial_data_o
);

    // A digital receiver sees the pin only when it is an input,
    // not analog and not taken by programming.
    function automatic logic dig_in(input logic dir, input logic ana, input logic ovr,
                                    input logic lvl);
        dig_in = dir & ~ana & ~ovr & lvl;
    endfunction : dig_in

    // Pin drive from one source chosen ahead of the latch.
    function automatic pbmux_drive_t pick(input logic dir, input logic sel, input logic src,
                                          input logic lat);
        pick.enable = ~dir;
        pick.level = sel ? src : lat;
    endfunction : pick

    pbmux_fuse_t fuse;
    logic fuse_load;
    logic [PORT_W-1:0] pin_sync;
    logic [0:0] portc_sync;
    logic [ANA_W-1:0] analog_sel;

    // Fuse levels are static after power-up, so one capture edge is enough
    pbmux_fuse_latch u_fuse (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .fuse_pins_i(fuse_pins_i),
        .fuse_o(fuse),
        .load_o(fuse_load)
    );

    // Pad levels are asynchronous; two stages before any receiver reads them
    pbmux_sync #(
        .WIDTH(PORT_W)
    ) u_sync_b (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .async_i(portb_pin_i),
        .sync_o(pin_sync)
    );

    pbmux_sync #(
        .WIDTH(1)
    ) u_sync_c (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .async_i(portc_bit1_pin_i),
        .sync_o(portc_sync)
    );

    // Mode decode
    wire prog_on = prog_debug_active_i;
    wire lvp_on = fuse.low_voltage_prog_fuse;
    wire capture_compare_ch2_rb3 = ~fuse.alt_capture_pin_fuse;
    wire capture_compare_ch2_rc1 = fuse.alt_capture_pin_fuse;

    // Pins taken away from their port functions
    wire [PORT_W-1:0] ovr;
    // Override beats direction and analog select, so a programmer never fights a pad
    assign ovr = {prog_on, prog_on, lvp_on, 5'h00};

    wire [PORT_W-1:0] ana;
    assign ana = {{(PORT_W-ANA_W){1'b0}}, analog_sel};

    // Analog select, loaded from the fuse once after power-on reset
    // A write landing on the load edge is lost; software writes after the preset
    wire [ANA_W-1:0] next_analog_sel =
        fuse_load ? (fuse.analog_default_fuse ? `PBMUX_ANSEL_ALL : `PBMUX_ANSEL_RST) :
        analog_sel_wr_i ? analog_sel_wdata_i : analog_sel;

    // Drive selection per pin; analog select never enters here
    wire use_c = PIN28 & epwm_en_i[`PBMUX_EPWM_C];
    wire use_b = PIN28 & epwm_en_i[`PBMUX_EPWM_B];
    wire use_d = PIN28 & epwm_en_i[`PBMUX_EPWM_D];
    wire use_capture_compare_ch2 = capture_compare_ch2_rb3 & capture_compare_ch2_en_i;

    // One source per pad: the function picks a peripheral over the latch
    pbmux_drive_t drv [PORT_W];
    assign drv[0] = pick(direction_bit_i[0], 1'b0, 1'b0, portb_output_latch_i[0]);
    assign drv[1] = pick(direction_bit_i[1], use_c, epwm_out_c_i, portb_output_latch_i[1]);
    assign drv[2] = pick(direction_bit_i[2], use_b, epwm_out_b_i, portb_output_latch_i[2]);
    assign drv[3] = pick(direction_bit_i[3], use_capture_compare_ch2, capture_compare_ch2_i,
                         portb_output_latch_i[3]);
    assign drv[4] = pick(direction_bit_i[4], use_d, epwm_out_d_i, portb_output_latch_i[4]);

    // Entry pin is input only under the low-voltage fuse
    pbmux_drive_t drv5_port;
    assign drv5_port = pick(direction_bit_i[5], 1'b0, 1'b0, portb_output_latch_i[5]);
    assign drv[5].enable = drv5_port.enable & ~lvp_on;
    assign drv[5].level = drv5_port.level;

    // Programming clock pin never driven while programming is active
    pbmux_drive_t drv6_port;
    assign drv6_port = pick(direction_bit_i[6], 1'b0, 1'b0, portb_output_latch_i[6]);
    assign drv[6].enable = drv6_port.enable & ~prog_on;
    assign drv[6].level = drv6_port.level;

    // While programming is active, data pin direction follows the programming engine, not the direction bit
    // The engine owns the turnaround; a clash with the programmer is its to avoid
    pbmux_drive_t drv7_port;
    assign drv7_port = pick(direction_bit_i[7], 1'b0, 1'b0, portb_output_latch_i[7]);
    assign drv[7].enable = prog_on ? prog_data_oe_i : drv7_port.enable;
    assign drv[7].level = prog_on ? prog_data_out_i : drv7_port.level;

    wire [PORT_W-1:0] next_pin;
    wire [PORT_W-1:0] next_oe;
    wire [PORT_W-1:0] next_pullup;
    wire [PORT_W-1:0] next_data;

    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        assign next_pin[i] = drv[i].level;
        assign next_oe[i] = drv[i].enable;
        // Pull-up only on an undriven digital input
        assign next_pullup[i] = pullup_enable_bits_i[i] & ~pullup_global_dis_i
                                & ~drv[i].enable & ~ana[i] & ~ovr[i];
        // Analog pins read as zero
        assign next_data[i] = dig_in(direction_bit_i[i], ana[i], ovr[i], pin_sync[i]);
    end

    // Interrupt and change-detect receivers
    wire [2:0] next_irq;
    for (genvar k = 0; k < 3; k++) begin : g_irq
        assign next_irq[k] = dig_in(direction_bit_i[k], ana[k], ovr[k], pin_sync[k]);
    end

    // Bits 6 and 7 lose their key lines while programming, through the override
    wire [3:0] next_key;
    for (genvar k = 0; k < 4; k++) begin : g_key
        localparam int B = `PBMUX_KEY_BASE + k;
        assign next_key[k] = dig_in(direction_bit_i[B], ana[B], ovr[B], pin_sync[B]);
    end

    // Bit 0 is never taken by programming, so the fault path skips the override
    wire next_fault = pwm_fault_en_i & dig_in(direction_bit_i[`PBMUX_BIT_FAULT],
                                              ana[`PBMUX_BIT_FAULT], 1'b0,
                                              pin_sync[`PBMUX_BIT_FAULT]);

    // Capture input comes from whichever pin owns channel 2
    wire cap_b = dig_in(direction_bit_i[`PBMUX_BIT_CAPTURE_COMPARE_CH2], ana[`PBMUX_BIT_CAPTURE_COMPARE_CH2], 1'b0,
                        pin_sync[`PBMUX_BIT_CAPTURE_COMPARE_CH2]);
    // Port C bit 1 has no analog option here, so only its direction gates capture
    wire cap_c = portc_bit1_dir_i & portc_sync[0];
    wire next_capture = capture_compare_ch2_rb3 ? cap_b : cap_c;

    // Port C bit 1: compare/PWM output wins over latch there
    wire next_pc1 = (capture_compare_ch2_rc1 & capture_compare_ch2_en_i) ? capture_compare_ch2_i : portc_bit1_latch_i;
    wire next_pc1_oe = ~portc_bit1_dir_i;

    // Converter channel enables, indexed from the lowest channel on this port
    wire [ANA_W-1:0] next_ch_en;
    assign next_ch_en[`PBMUX_CH_OF_BIT0 - `PBMUX_ANA_CH_BASE] = analog_sel[0];
    assign next_ch_en[`PBMUX_CH_OF_BIT1 - `PBMUX_ANA_CH_BASE] = analog_sel[1];
    assign next_ch_en[`PBMUX_CH_OF_BIT2 - `PBMUX_ANA_CH_BASE] = analog_sel[2];
    assign next_ch_en[`PBMUX_CH_OF_BIT3 - `PBMUX_ANA_CH_BASE] = analog_sel[3];
    assign next_ch_en[`PBMUX_CH_OF_BIT4 - `PBMUX_ANA_CH_BASE] = analog_sel[4];

    // Comparators share the converter's select
    wire next_cmp2 = analog_sel[`PBMUX_BIT_CAPTURE_COMPARE_CH2];
    wire next_cmp3 = analog_sel[`PBMUX_BIT_EPWM_C];

    // Programming receivers, Schmitt inputs ignoring direction
    wire next_entry = lvp_on & pin_sync[`PBMUX_BIT_PROG_ENTRY];
    wire next_pclk = prog_on & pin_sync[`PBMUX_BIT_PROG_CLK];
    wire next_pdat = prog_on & ~prog_data_oe_i & pin_sync[`PBMUX_BIT_PROG_DATA];

    // Every output is a flip-flop; the pins lag their controls by one edge,
    // traded for glitch-free pads.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            analog_sel <= `PBMUX_ANSEL_RST;
            portb_pin_o <= `PBMUX_PORT_RST;
            portb_pin_oe_o <= `PBMUX_PORT_RST;
            portb_pullup_o <= `PBMUX_PORT_RST;
            portb_data_o <= `PBMUX_PORT_RST;
        end else if (clk_en_i) begin
            analog_sel <= next_analog_sel;
            portb_pin_o <= next_pin;
            portb_pin_oe_o <= next_oe;
            portb_pullup_o <= next_pullup;
            portb_data_o <= next_data;
        end
    end

    // Port C controls one edge after their inputs like the pins; analog controls two edges after the select write
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            portc_bit1_pin_o <= 1'b0;
            portc_bit1_pin_oe_o <= 1'b0;
            analog_sel_o <= `PBMUX_ANSEL_RST;
            analog_ch_en_o <= `PBMUX_ANSEL_RST;
            comparator_neg_in2_en_o <= 1'b0;
            comparator_neg_in3_en_o <= 1'b0;
            capture_compare_ch2_on_portb_o <= 1'b0;
        end else if (clk_en_i) begin
            portc_bit1_pin_o <= next_pc1;
            portc_bit1_pin_oe_o <= next_pc1_oe;
            analog_sel_o <= analog_sel;
            analog_ch_en_o <= next_ch_en;
            comparator_neg_in2_en_o <= next_cmp2;
            comparator_neg_in3_en_o <= next_cmp3;
            capture_compare_ch2_on_portb_o <= capture_compare_ch2_rb3;
        end
    end

    // Receivers: three edges after the pad, two of them in the synchroniser
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_irq_in_o <= 3'h0;
            key_change_in_o <= 4'h0;
            pwm_fault_in_o <= 1'b0;
            capture_compare_ch2_capture_o <= 1'b0;
            prog_entry_input_o <= 1'b0;
            prog_serial_clock_o <= 1'b0;
            prog_serial_data_o <= 1'b0;
        end else if (clk_en_i) begin
            ext_irq_in_o <= next_irq;
            key_change_in_o <= next_key;
            pwm_fault_in_o <= next_fault;
            capture_compare_ch2_capture_o <= next_capture;
            prog_entry_input_o <= next_entry;
            prog_serial_clock_o <= next_pclk;
            prog_serial_data_o <= next_pdat;
        end
    end

endmodule : pbmux_top
`default_nettype wire

// ==== tb/pbmux_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbmux_props (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] direction_bit_i,
    input wire logic [7:0] portb_output_latch_i,
    input wire logic pullup_global_dis_i,
    input wire logic [2:0] epwm_en_i,
    input wire logic epwm_out_c_i,
    input wire logic prog_debug_active_i,
    input wire logic prog_data_oe_i,
    input wire logic [7:0] portb_pin_o,
    input wire logic [7:0] portb_pin_oe_o,
    input wire logic [7:0] portb_pullup_o,
    input wire logic [7:0] portb_data_o,
    input wire logic [4:0] analog_sel_o,
    input wire logic [4:0] analog_ch_en_o,
    input wire logic comparator_neg_in2_en_o,
    input wire logic comparator_neg_in3_en_o,
    input wire logic [2:0] ext_irq_in_o,
    input wire logic [3:0] key_change_in_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_drive_latch;
        !direction_bit_i[0] |=> portb_pin_oe_o[0] && portb_pin_o[0] == $past(portb_output_latch_i[0]);
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("bit0 not driven from latch");
    property p_pwm_c;
        epwm_en_i[1] && !direction_bit_i[1] |=> portb_pin_oe_o[1] && portb_pin_o[1] == $past(epwm_out_c_i);
    endproperty
    a_pwm_c: assert property (p_pwm_c) else $error("pwm c not on bit1");
    property p_pullup_gdis;
        pullup_global_dis_i |=> portb_pullup_o == 8'h00;
    endproperty
    a_pullup_gdis: assert property (p_pullup_gdis) else $error("pull-up despite global disable");
    property p_pullup_out;
        (portb_pullup_o & portb_pin_oe_o) == 8'h00;
    endproperty
    a_pullup_out: assert property (p_pullup_out) else $error("pull-up on driven pin");
    property p_prog_clk;
        prog_debug_active_i |=> !portb_pin_oe_o[6] && !portb_pullup_o[6];
    endproperty
    a_prog_clk: assert property (p_prog_clk) else $error("bit6 used while programming");
    property p_prog_data;
        prog_debug_active_i |=> portb_pin_oe_o[7] == $past(prog_data_oe_i);
    endproperty
    a_prog_data: assert property (p_prog_data) else $error("bit7 drive not set by programming");
    property p_ch_map;
        analog_ch_en_o == {analog_sel_o[0], analog_sel_o[4], analog_sel_o[1], analog_sel_o[3], analog_sel_o[2]};
    endproperty
    a_ch_map: assert property (p_ch_map) else $error("converter channel map wrong");
    property p_cmp;
        comparator_neg_in3_en_o == analog_sel_o[1] && comparator_neg_in2_en_o == analog_sel_o[3];
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator input map wrong");
    property p_ana_in;
        (analog_sel_o & (portb_data_o[4:0] | portb_pullup_o[4:0])) == 5'h00;
    endproperty
    a_ana_in: assert property (p_ana_in) else $error("analog pin reads data or pulls up");
    property p_irq;
        ext_irq_in_o == portb_data_o[2:0] ##0 key_change_in_o == portb_data_o[7:4];
    endproperty
    a_irq: assert property (p_irq) else $error("irq or key line differs from pin input");
endmodule : pbmux_props
bind pbmux_top pbmux_props i_props (.clk_i(clk_i), .reset_i(reset_i), .direction_bit_i(direction_bit_i),
    .portb_output_latch_i(portb_output_latch_i), .pullup_global_dis_i(pullup_global_dis_i),
    .epwm_en_i(epwm_en_i), .epwm_out_c_i(epwm_out_c_i), .prog_debug_active_i(prog_debug_active_i),
    .prog_data_oe_i(prog_data_oe_i), .portb_pin_o(portb_pin_o), .portb_pin_oe_o(portb_pin_oe_o),
    .portb_pullup_o(portb_pullup_o), .portb_data_o(portb_data_o), .analog_sel_o(analog_sel_o),
    .analog_ch_en_o(analog_ch_en_o), .comparator_neg_in2_en_o(comparator_neg_in2_en_o),
    .comparator_neg_in3_en_o(comparator_neg_in3_en_o), .ext_irq_in_o(ext_irq_in_o),
    .key_change_in_o(key_change_in_o));
`default_nettype wire

// ==== tb/pbmux_pins.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbmux_pins (
    input wire logic clk_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] pin_o
);
    logic flt = 1'b0;
    // Floating pins wander so a stale level never passes as valid
    always @(posedge clk_i) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Programmer clock and data come in on the outside drive
            pin_o[i] = oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] : pullup_i[i] ? 1'b1 : flt;
        end
    end
endmodule : pbmux_pins
`default_nettype wire

// ==== tb/pbmux_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbmux_top_tb;
    import pbmux_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    pbmux_fuse_t fuse = 3'b110;
    logic [7:0] dir = 8'hFF, lat = 8'h00, pue = 8'hFF, ext = 8'hFF, ext_en = 8'hFF, pin_in;
    logic gdis = 1'b0, wr = 1'b0, ccp_en = 1'b1, ccp = 1'b1, flt_en = 1'b1, prog = 1'b0, pd_oe = 1'b0, pd = 1'b0;
    logic clk_en = 1'b1, pc_dir = 1'b0, pc_pin = 1'b1;
    logic [4:0] wdata = 5'h00;
    logic [2:0] pwm_en = 3'h0, pwm = 3'h0;
    logic [7:0] pin_o, oe_o, pu_o, data_o;
    logic [4:0] sel_o, ch_o;
    logic [2:0] irq_o;
    logic [3:0] key_o;
    logic pc_o, pc_oe, cm2, cm3, fault_o, cap_o, on_b, entry_o, pclk_o, pdat_o;
    int miscompares = 0;
    int checked = 0;
    initial forever #25 clk_i = ~clk_i;
    pbmux_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .fuse_pins_i(fuse),
        .direction_bit_i(dir), .portb_output_latch_i(lat), .pullup_enable_bits_i(pue),
        .pullup_global_dis_i(gdis), .analog_sel_wr_i(wr), .analog_sel_wdata_i(wdata), .epwm_en_i(pwm_en),
        .epwm_out_b_i(pwm[0]), .epwm_out_c_i(pwm[1]), .epwm_out_d_i(pwm[2]), .capture_compare_ch2_en_i(ccp_en),
        .capture_compare_ch2_i(ccp), .pwm_fault_en_i(flt_en), .prog_debug_active_i(prog),
        .prog_data_oe_i(pd_oe), .prog_data_out_i(pd), .portc_bit1_dir_i(pc_dir), .portc_bit1_latch_i(1'b0),
        .portb_pin_i(pin_in), .portc_bit1_pin_i(pc_pin), .portb_pin_o(pin_o), .portb_pin_oe_o(oe_o),
        .portb_pullup_o(pu_o), .portc_bit1_pin_o(pc_o), .portc_bit1_pin_oe_o(pc_oe), .portb_data_o(data_o),
        .analog_sel_o(sel_o), .analog_ch_en_o(ch_o), .comparator_neg_in2_en_o(cm2),
        .comparator_neg_in3_en_o(cm3), .ext_irq_in_o(irq_o), .key_change_in_o(key_o),
        .pwm_fault_in_o(fault_o), .capture_compare_ch2_capture_o(cap_o), .capture_compare_ch2_on_portb_o(on_b),
        .prog_entry_input_o(entry_o), .prog_serial_clock_o(pclk_o), .prog_serial_data_o(pdat_o));
    pbmux_pins i_pins (.clk_i(clk_i), .drv_i(pin_o), .oe_i(oe_o), .pullup_i(pu_o), .ext_i(ext),
        .ext_en_i(ext_en), .pin_o(pin_in));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic do_reset(input pbmux_fuse_t f);
        @(posedge clk_i);
        reset_i <= 1'b1;
        fuse <= f;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        tick(4);
    endtask : do_reset
    task automatic t_fuse_default();
        do_reset(3'b110);
        cmp(sel_o, 8'h1F);
        cmp(ch_o, 8'h1F);
        cmp(pu_o, 8'hE0);
        cmp(data_o, 8'hE0);
        cmp({on_b, pc_oe, pc_o}, 8'h03);
        @(posedge clk_i);
        pc_dir <= 1'b1;
        ccp_en <= 1'b0;
        tick(4);
        cmp({pc_oe, pc_o, cap_o}, 8'h01);
        @(posedge clk_i);
        pc_dir <= 1'b0;
        ccp_en <= 1'b1;
    endtask : t_fuse_default
    task automatic t_latch();
        @(posedge clk_i);
        dir <= 8'h00;
        lat <= 8'hA5;
        tick(1);
        cmp(oe_o, 8'hFF);
        cmp(pin_o, 8'hA5);
        cmp(pu_o, 8'h00);
        @(posedge clk_i);
        clk_en <= 1'b0;
        lat <= 8'h25;
        tick(2);
        cmp(pin_o, 8'hA5);
        @(posedge clk_i);
        clk_en <= 1'b1;
    endtask : t_latch
    task automatic t_pwm();
        @(posedge clk_i);
        lat <= 8'h00;
        pwm_en <= 3'h7;
        pwm <= 3'b101;
        tick(1);
        cmp(pin_o, 8'h14);
        @(posedge clk_i);
        pwm <= 3'b010;
        tick(1);
        cmp(pin_o, 8'h02);
    endtask : t_pwm
    task automatic write_sel(input logic [4:0] v);
        @(posedge clk_i);
        wr <= 1'b1;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'b0;
        tick(2);
    endtask : write_sel
    task automatic t_analog_wr();
        write_sel(5'h03);
        cmp(sel_o, 8'h03);
        cmp(ch_o, 8'h14);
        cmp({cm2, cm3}, 8'h01);
        write_sel(5'h08);
        cmp(ch_o, 8'h02);
        cmp({cm2, cm3}, 8'h02);
        write_sel(5'h00);
    endtask : t_analog_wr
    task automatic t_inputs();
        @(posedge clk_i);
        pwm_en <= 3'h0;
        dir <= 8'hFF;
        ext <= 8'h5B;
        tick(4);
        cmp(data_o, 8'h5B);
        cmp(irq_o, 8'h03);
        cmp(key_o, 8'h05);
        cmp(fault_o, 8'h01);
        @(posedge clk_i);
        flt_en <= 1'b0;
        tick(4);
        cmp(fault_o, 8'h00);
    endtask : t_inputs
    task automatic t_prog();
        @(posedge clk_i);
        prog <= 1'b1;
        dir <= 8'h00;
        lat <= 8'hFF;
        ext <= 8'h40;
        tick(4);
        cmp(oe_o, 8'h3F);
        cmp({pclk_o, pdat_o, key_o[3:2]}, 8'h08);
        @(posedge clk_i);
        ext <= 8'h80;
        tick(4);
        cmp({pclk_o, pdat_o}, 8'h01);
        @(posedge clk_i);
        pd_oe <= 1'b1;
        pd <= 1'b1;
        ext_en <= 8'h40;
        tick(1);
        cmp({oe_o[7], pin_o[7]}, 8'h03);
        @(posedge clk_i);
        prog <= 1'b0;
        ext_en <= 8'hFF;
        ext <= 8'hFF;
    endtask : t_prog
    task automatic t_alt_fuse();
        do_reset(3'b001);
        cmp(sel_o, 8'h00);
        cmp(on_b, 8'h01);
        @(posedge clk_i);
        dir <= 8'hD7;
        lat <= 8'h00;
        tick(4);
        cmp(oe_o, 8'h08);
        cmp(pin_o[3], 8'h01);
        cmp(pu_o, 8'hD7);
        cmp({entry_o, data_o[5]}, 8'h02);
        @(posedge clk_i);
        dir <= 8'hDF;
        gdis <= 1'b1;
        tick(4);
        cmp(cap_o, 8'h01);
        cmp(pu_o, 8'h00);
    endtask : t_alt_fuse
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    int cycles = 0;
    initial begin
        while (cycles < 2000) begin
            @(posedge clk_i);
            cycles++;
        end
        miscompares++;
        complete_run();
    end
    initial begin
        t_fuse_default();
        t_latch();
        t_pwm();
        t_analog_wr();
        t_inputs();
        t_prog();
        t_alt_fuse();
        complete_run();
    end
endmodule : pbmux_top_tb
`default_nettype wire
